// ==== verilog/hrb_pkg.sv ====
// Constants, register map and helpers for the handler-return branch unit.
// Assumes a 32-bit core datapath and a 32-bit Avalon-MM register bus.
package hrb_pkg;

   typedef enum logic [1:0] {
      KIND_BREAK = 2'b00,
      KIND_INTR = 2'b01,
      KIND_EXC = 2'b10
   } ret_kind_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SLOT = 2'b01
   } ret_state_e;

   // Byte offsets of the register map
   localparam logic [4:0] OFS_MACH_STAT = 5'h00;
   localparam logic [4:0] OFS_EXC_STAT = 5'h04;
   localparam logic [4:0] OFS_CFG = 5'h08;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h0C;
   localparam logic [4:0] OFS_IRQ_EN = 5'h10;
   localparam logic [4:0] OFS_IRQ_CLR = 5'h14;
   localparam logic [4:0] OFS_TARGET = 5'h18;

   // machine_status_register field positions
   localparam int BIT_INT_EN = 0;
   localparam int BIT_BRK_BUSY = 1;
   localparam int BIT_EXC_EN = 2;
   localparam int BIT_EXC_BUSY = 3;
   localparam int BIT_USER = 4;
   localparam int BIT_USER_SAVED = 5;
   localparam int BIT_VIRT = 6;
   localparam int BIT_VIRT_SAVED = 7;

   // Interrupt status bit positions
   localparam int IRQ_PRIV = 0;
   localparam int IRQ_RET = 1;

   localparam logic [7:0] MACH_STAT_RST = 8'h00;
   localparam logic [31:0] EXC_STAT_RST = 32'h0000_0000;
   localparam logic CFG_MMU_RST = 1'b0;
   localparam logic [1:0] IRQ_EN_RST = 2'h0;
   localparam logic [4:0] CAUSE_PRIV = 5'h07;

   function automatic logic [31:0] sext16(input logic [15:0] imm);
      sext16 = {{16{imm[15]}}, imm};
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
      be_merge = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            be_merge[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
   endfunction

endpackage

// ==== verilog/hrb_target_calc.sv ====
// Branch target adder and privilege check for the handler-return unit.
// Purely combinational; inputs come from the core's own clock domain.
`timescale 1ns/10ps
module hrb_target_calc
   import hrb_pkg::*;
(
   input wire logic [31:0] i_src_a,
   input wire logic [15:0] i_imm,
   input wire logic i_mmu_on,
   input wire logic i_user_mode,
   output logic [31:0] o_target,
   output logic o_privileged
);

   assign o_target = i_src_a + sext16(i_imm);
   assign o_privileged = i_mmu_on && i_user_mode;

endmodule

// ==== verilog/hrb_unit.sv ====
// Handler-return branch unit: return from break, interrupt and exception.
// Sits in the core pipeline on the core clock; status registers on Avalon-MM.
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps

// Function
// - Target is source register plus sign-extended immediate
// - Return-from-break clears break-in-progress flag
// - Delay slot after break return keeps breaks disabled
// - Return-from-interrupt sets interrupt enable flag
// - Delay slot after interrupt return keeps interrupts off
// - Exception return enables exceptions, clears status
// - User mode with MMU option traps, cause 00111
// - Following instruction runs as delay slot unless the return traps
// - Interrupts and hardware breaks held until slot done
module hrb_unit
   import hrb_pkg::*;
(
   input wire logic I_SYS_CLK,
   input wire logic I_RSTN,
   input wire logic I_ISSUE_VALID,
   input wire logic [1:0] I_ISSUE_KIND,
   input wire logic [31:0] I_SRC_A,
   input wire logic [15:0] I_IMM,
   input wire logic I_SLOT_DONE,
   input wire logic [4:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   output logic O_READY,
   output logic O_BRANCH_VALID,
   output logic [31:0] O_BRANCH_TARGET,
   output logic O_PRIV_EXC,
   output logic O_DEFER,
   output logic O_INT_ALLOW,
   output logic O_BRK_ALLOW,
   output logic O_EXC_ENABLE,
   output logic O_USER_MODE,
   output logic O_VIRT_MODE,
   output logic O_IRQ
);

   ret_state_e state_reg, state_next;
   ret_kind_e kind_reg, kind_next;
   logic [31:0] target_reg, target_next;
   logic [7:0] mstat_reg, mstat_next;
   logic [31:0] estat_reg, estat_next;
   logic mmu_reg, mmu_next;
   logic [1:0] irq_stat_reg, irq_stat_next;
   logic [1:0] irq_en_reg, irq_en_next;
   logic irq_reg;
   logic waitreq_reg, waitreq_next;
   logic [31:0] rdata_reg, rdata_next;
   logic branch_reg, priv_reg;
   logic int_ok_reg, brk_ok_reg, defer_reg, ready_reg;

   wire logic [31:0] calc_target;
   wire logic privileged;
   wire logic idle = (state_reg == ST_IDLE);
   // Issue refused until ready is shown, also in the first cycle after reset
   wire logic issue = I_ISSUE_VALID && idle && ready_reg;
   wire logic fault = issue && privileged;
   wire logic start = issue && !privileged;
   wire logic finish = (state_reg == ST_SLOT) && I_SLOT_DONE;
   wire logic bus_req = I_AVS_READ || I_AVS_WRITE;
   wire logic wr_fire = I_AVS_WRITE && !waitreq_reg;
   wire logic aligned = (I_AVS_ADDRESS[1:0] == 2'b00);
   wire logic sel_mstat = aligned && (I_AVS_ADDRESS == OFS_MACH_STAT);
   wire logic sel_estat = aligned && (I_AVS_ADDRESS == OFS_EXC_STAT);
   wire logic sel_cfg = aligned && (I_AVS_ADDRESS == OFS_CFG);
   wire logic sel_stat = aligned && (I_AVS_ADDRESS == OFS_IRQ_STAT);
   wire logic sel_en = aligned && (I_AVS_ADDRESS == OFS_IRQ_EN);
   wire logic sel_clr = aligned && (I_AVS_ADDRESS == OFS_IRQ_CLR);
   wire logic sel_tgt = aligned && (I_AVS_ADDRESS == OFS_TARGET);
   wire logic [31:0] wr_mstat = be_merge({24'h000000, mstat_reg}, I_AVS_WRITEDATA,
                                         I_AVS_BYTEENABLE);
   wire logic [31:0] wr_estat = be_merge(estat_reg, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
   wire logic [1:0] clr_mask = (wr_fire && sel_clr && I_AVS_BYTEENABLE[0]) ?
                               I_AVS_WRITEDATA[1:0] : 2'h0;
   wire logic [1:0] events = {finish, fault};
   wire logic slot_next = (state_next == ST_SLOT);

   hrb_target_calc u_calc (
      .i_src_a(I_SRC_A),
      .i_imm(I_IMM),
      .i_mmu_on(mmu_reg),
      .i_user_mode(mstat_reg[BIT_USER]),
      .o_target(calc_target),
      .o_privileged(privileged)
   );

   // Sequencer: the branch is held back until the slot instruction retires
   always_comb begin
      state_next = state_reg;
      kind_next = kind_reg;
      target_next = target_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start) begin
               state_next = ST_SLOT;
               kind_next = ret_kind_e'(I_ISSUE_KIND);
               target_next = calc_target;
            end
         end
         ST_SLOT: begin
            // Slot is assumed free of imm, branch and break, so one retire ends it
            if (I_SLOT_DONE) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // Flags change only once the slot has retired, so the slot runs under old flags
   always_comb begin
      mstat_next = mstat_reg;
      if (wr_fire && sel_mstat) begin
         mstat_next = wr_mstat[7:0];
      end
      if (finish) begin
         case (kind_reg)
            KIND_BREAK: mstat_next[BIT_BRK_BUSY] = 1'b0;
            KIND_INTR: mstat_next[BIT_INT_EN] = 1'b1;
            KIND_EXC: begin
               mstat_next[BIT_EXC_EN] = 1'b1;
               mstat_next[BIT_EXC_BUSY] = 1'b0;
            end
            default: ;
         endcase
         mstat_next[BIT_USER] = mstat_reg[BIT_USER_SAVED];
         mstat_next[BIT_VIRT] = mstat_reg[BIT_VIRT_SAVED];
      end
   end

   always_comb begin
      estat_next = estat_reg;
      if (wr_fire && sel_estat) begin
         estat_next = wr_estat;
      end
      if (fault) begin
         estat_next[4:0] = CAUSE_PRIV;
      end
      if (finish && (kind_reg == KIND_EXC)) begin
         estat_next = EXC_STAT_RST;
      end
   end

   assign mmu_next = (wr_fire && sel_cfg && I_AVS_BYTEENABLE[0]) ?
                     I_AVS_WRITEDATA[0] : mmu_reg;
   assign irq_en_next = (wr_fire && sel_en && I_AVS_BYTEENABLE[0]) ?
                        I_AVS_WRITEDATA[1:0] : irq_en_reg;
   // A new event beats a clear landing in the same cycle
   assign irq_stat_next = (irq_stat_reg & ~clr_mask) | events;

   // One wait state: the answer is registered, keeping readdata off the decode path
   assign waitreq_next = !(bus_req && waitreq_reg);
   assign rdata_next = !(I_AVS_READ && waitreq_reg) ? rdata_reg :
                       sel_mstat ? {24'h000000, mstat_reg} :
                       sel_estat ? estat_reg :
                       sel_cfg ? {31'h00000000, mmu_reg} :
                       sel_stat ? {30'h00000000, irq_stat_reg} :
                       sel_en ? {30'h00000000, irq_en_reg} :
                       sel_tgt ? target_reg : 32'h0000_0000;

   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         state_reg <= ST_IDLE;
         kind_reg <= KIND_BREAK;
         target_reg <= 32'h0000_0000;
         mstat_reg <= MACH_STAT_RST;
         estat_reg <= EXC_STAT_RST;
         mmu_reg <= CFG_MMU_RST;
      end else begin
         state_reg <= state_next;
         kind_reg <= kind_next;
         target_reg <= target_next;
         mstat_reg <= mstat_next;
         estat_reg <= estat_next;
         mmu_reg <= mmu_next;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         irq_stat_reg <= 2'h0;
         irq_en_reg <= IRQ_EN_RST;
         irq_reg <= 1'b0;
         waitreq_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_en_reg <= irq_en_next;
         irq_reg <= |(irq_stat_next & irq_en_next);
         waitreq_reg <= waitreq_next;
         rdata_reg <= rdata_next;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         branch_reg <= 1'b0;
         priv_reg <= 1'b0;
         defer_reg <= 1'b0;
         int_ok_reg <= 1'b0;
         brk_ok_reg <= 1'b0;
         ready_reg <= 1'b0;
      end else begin
         branch_reg <= finish;
         priv_reg <= fault;
         defer_reg <= slot_next;
         // Allow flags drop with the issue edge, so nothing slips in as the slot starts
         int_ok_reg <= mstat_next[BIT_INT_EN] && !slot_next;
         brk_ok_reg <= !mstat_next[BIT_BRK_BUSY] && !slot_next;
         ready_reg <= !slot_next;
      end
   end

   assign O_AVS_READDATA = rdata_reg;
   assign O_AVS_WAITREQUEST = waitreq_reg;
   assign O_READY = ready_reg;
   assign O_BRANCH_VALID = branch_reg;
   assign O_BRANCH_TARGET = target_reg;
   assign O_PRIV_EXC = priv_reg;
   assign O_DEFER = defer_reg;
   assign O_INT_ALLOW = int_ok_reg;
   assign O_BRK_ALLOW = brk_ok_reg;
   assign O_EXC_ENABLE = mstat_reg[BIT_EXC_EN];
   assign O_USER_MODE = mstat_reg[BIT_USER];
   assign O_VIRT_MODE = mstat_reg[BIT_VIRT];
   assign O_IRQ = irq_reg;

   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (!I_RSTN);

   chk_target_sum: assert property (
      start |=> O_BRANCH_TARGET == ($past(I_SRC_A) + sext16($past(I_IMM))))
      else $error("branch target is not source plus sign-extended immediate");

   chk_bip_clear: assert property (
      (finish && kind_reg == KIND_BREAK) |=> !mstat_reg[BIT_BRK_BUSY] ##0 O_BRK_ALLOW)
      else $error("break return did not clear break-in-progress");

   chk_slot_nobreak: assert property (
      (start && I_ISSUE_KIND == KIND_BREAK) |=> !O_BRK_ALLOW until_with finish)
      else $error("break allowed during delay slot");

   chk_ie_set: assert property (
      (finish && kind_reg == KIND_INTR) |=> mstat_reg[BIT_INT_EN] && O_INT_ALLOW)
      else $error("interrupt return did not enable interrupts");

   chk_slot_noint: assert property (
      (state_reg == ST_SLOT) |-> !O_INT_ALLOW)
      else $error("interrupts allowed during delay slot");

   chk_exc_flags: assert property (
      (finish && kind_reg == KIND_EXC) |=>
         mstat_reg[BIT_EXC_EN] && !mstat_reg[BIT_EXC_BUSY] && estat_reg == 32'h0000_0000)
      else $error("exception return flags or status wrong");

   chk_priv_trap: assert property (
      fault |=> O_PRIV_EXC && estat_reg[4:0] == CAUSE_PRIV && state_reg == ST_IDLE
         && !O_BRANCH_VALID)
      else $error("privileged return did not trap");

   chk_branch_after_slot: assert property (
      $rose(O_BRANCH_VALID) |-> $past(state_reg) == ST_SLOT && $past(I_SLOT_DONE))
      else $error("branch taken without a retired delay slot");

   chk_defer_hold: assert property (
      start |=> (O_DEFER && !O_READY) until_with finish)
      else $error("interrupt hold-off dropped before slot retired");

   chk_mode_restore: assert property (
      finish |=> O_USER_MODE == $past(mstat_reg[BIT_USER_SAVED])
         && O_VIRT_MODE == $past(mstat_reg[BIT_VIRT_SAVED]))
      else $error("mode bits not restored from saved copies");

   // Exactly one wait state; a master that counts on it must not hang
   chk_bus_answer: assert property (
      (bus_req && O_AVS_WAITREQUEST) |=> !O_AVS_WAITREQUEST)
      else $error("bus request not answered after one wait state");

   chk_irq_level: assert property (
      O_IRQ == |(irq_stat_reg & irq_en_reg))
      else $error("interrupt line does not follow enabled status");

   // Sticky until software clears it
   chk_stat_sticky: assert property (
      (irq_stat_reg[IRQ_RET] && !clr_mask[IRQ_RET]) |=> irq_stat_reg[IRQ_RET])
      else $error("return status bit lost without a clear");

   cov_break_ret: cover property (start && I_ISSUE_KIND == KIND_BREAK ##[1:20] finish);
   cov_intr_ret: cover property (finish && kind_reg == KIND_INTR);
   cov_exc_ret: cover property (finish && kind_reg == KIND_EXC);
   cov_priv_trap: cover property (fault ##1 O_IRQ);
   cov_long_slot: cover property (O_DEFER [*3]);

endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the handler-return branch unit.
// Assumes the unit answers every bus request with one wait state.
`timescale 1ns/10ps
module testbench
   import hrb_pkg::*;
;
   logic clk, rst_n, iss, slot;
   logic [1:0] kind;
   logic [31:0] src, wdata, rdata;
   logic [15:0] imm;
   logic [4:0] addr;
   logic rd, wr;
   logic [3:0] be;
   logic waitreq, ready, br_v, priv, defer, int_ok, brk_ok, exc_en, um, vm, irq;
   logic [31:0] tgt, rv;
   int n_errors, checked, cyc;

   hrb_unit dut (.I_SYS_CLK(clk), .I_RSTN(rst_n), .I_ISSUE_VALID(iss), .I_ISSUE_KIND(kind),
      .I_SRC_A(src), .I_IMM(imm), .I_SLOT_DONE(slot), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
      .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
      .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .O_READY(ready),
      .O_BRANCH_VALID(br_v), .O_BRANCH_TARGET(tgt), .O_PRIV_EXC(priv), .O_DEFER(defer),
      .O_INT_ALLOW(int_ok), .O_BRK_ALLOW(brk_ok), .O_EXC_ENABLE(exc_en),
      .O_USER_MODE(um), .O_VIRT_MODE(vm), .O_IRQ(irq));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("errors %0d, comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Ceiling well above the hundred-odd cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         results();
      end
   end

   // One Avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      k = 0;
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do begin
         @(posedge clk);
         k++;
      end while (waitreq !== 1'b0 && k < 20);
      rv = rdata;
      if (k >= 20) begin
         chk(1'b1, 1'b0);
      end
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rv, exp);
   endtask

   // Issue one return, hold the delay slot for n extra cycles, then complete it
   task automatic ret(input logic [1:0] k, input logic [31:0] s, input logic [15:0] i,
                      input logic [31:0] exp_tgt, input int n);
      iss <= 1'b1;
      kind <= k;
      src <= s;
      imm <= i;
      @(posedge clk);
      iss <= 1'b0;
      slot <= (n == 0);
      #1;
      chk(tgt, exp_tgt);
      for (int c = 0; c <= n; c++) begin
         chk({defer, ready, br_v}, 3'b100);
         chk({int_ok, brk_ok}, 2'b00);
         if (c < n) begin
            @(posedge clk);
            slot <= (c == n - 1);
            #1;
         end
      end
      @(posedge clk);
      slot <= 1'b0;
      #1;
      chk({br_v, defer, ready}, 3'b101);
      @(posedge clk);
   endtask

   initial begin
      rst_n = 1'b0;
      iss = 1'b0;
      slot = 1'b0;
      kind = 2'h0;
      src = 32'h0;
      imm = 16'h0;
      addr = 5'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0;
      be = 4'hF;
      n_errors = 0;
      checked = 0;
      cyc = 0;
      repeat (3) @(posedge clk);
      scen_reset();
      scen_regs();
      scen_break();
      scen_intr();
      scen_exc();
      scen_trap();
      scen_irq();
      results();
   end

   task automatic scen_reset();
      chk({waitreq, ready}, 2'b10);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk({ready, brk_ok, int_ok}, 3'b110);
   endtask

   task automatic scen_regs();
      rdchk(OFS_MACH_STAT, 32'h0);
      rdchk(OFS_EXC_STAT, 32'h0);
      rdchk(OFS_CFG, 32'h0);
      rdchk(OFS_IRQ_EN, 32'h0);
      rdchk(5'h1C, 32'h0);
      rdchk(5'h01, 32'h0);
   endtask

   // Break return: breaks stay off through the slot, modes restored
   task automatic scen_break();
      bus(1'b1, OFS_MACH_STAT, 32'h0000_00A2);
      ret(KIND_BREAK, 32'h0000_1000, 16'hFFF0, 32'h0000_0FF0, 2);
      chk({brk_ok, um, vm}, 3'b111);
      rdchk(OFS_MACH_STAT, 32'h0000_00F0);
      bus(1'b1, OFS_TARGET, 32'hFFFF_FFFF);
      rdchk(OFS_TARGET, 32'h0000_0FF0);
   endtask

   // Interrupt return with the slot done at once, then a kind with mode restore only
   task automatic scen_intr();
      bus(1'b1, OFS_MACH_STAT, 32'h0000_0000);
      ret(KIND_INTR, 32'hFFFF_0001, 16'h7FFF, 32'hFFFF_8000, 0);
      chk(int_ok, 1'b1);
      rdchk(OFS_MACH_STAT, 32'h0000_0001);
      bus(1'b1, OFS_MACH_STAT, 32'h0000_00A0);
      ret(2'h3, 32'h0000_0004, 16'h0004, 32'h0000_0008, 0);
      rdchk(OFS_MACH_STAT, 32'h0000_00F0);
   endtask

   // Exception return clears the cause register
   task automatic scen_exc();
      bus(1'b1, OFS_MACH_STAT, 32'h0000_0009);
      bus(1'b1, OFS_EXC_STAT, 32'hDEAD_BEEF);
      ret(KIND_EXC, 32'h0001_0000, 16'h8000, 32'h0000_8000, 1);
      chk({exc_en, int_ok, um}, 3'b110);
      rdchk(OFS_MACH_STAT, 32'h0000_0005);
      rdchk(OFS_EXC_STAT, 32'h0);
      chk(irq, 1'b0);
   endtask

   // Privileged trap for every kind in user mode with the option on
   task automatic scen_trap();
      bus(1'b1, OFS_CFG, 32'h0000_0001);
      bus(1'b1, OFS_MACH_STAT, 32'h0000_0010);
      for (int k = 0; k < 3; k++) begin
         iss <= 1'b1;
         kind <= k[1:0];
         @(posedge clk);
         iss <= 1'b0;
         #1;
         chk({priv, br_v, defer}, 3'b100);
         @(posedge clk);
         chk(br_v, 1'b0);
      end
      rdchk(OFS_EXC_STAT, 32'h0000_0007);
      rdchk(OFS_MACH_STAT, 32'h0000_0010);
   endtask

   // Interrupt: raise, mask, clear
   task automatic scen_irq();
      bus(1'b1, OFS_IRQ_EN, 32'h0000_0003);
      @(posedge clk);
      #1;
      chk(irq, 1'b1);
      rdchk(OFS_IRQ_STAT, 32'h0000_0003);
      bus(1'b1, OFS_IRQ_CLR, 32'h0000_0001);
      rdchk(OFS_IRQ_STAT, 32'h0000_0002);
      rdchk(OFS_IRQ_CLR, 32'h0);
      bus(1'b1, OFS_IRQ_EN, 32'h0000_0001);
      @(posedge clk);
      #1;
      chk(irq, 1'b0);
      bus(1'b1, OFS_IRQ_CLR, 32'h0000_0002);
      rdchk(OFS_IRQ_STAT, 32'h0);
   endtask
endmodule
